// ### src/xto_pkg.sv
// shared constants and types for the oscillator clock-out and synth word block
package xto_pkg;

	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_WORD_LOW  = 8'h04;
	localparam logic [7:0] ADDR_WORD_HIGH = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_RATIO     = 8'h10;

	// control register field positions
	localparam int CTRL_PERMIT_BIT  = 0;
	localparam int CTRL_REQUEST_BIT = 1;
	localparam int CTRL_BAND_BIT    = 2;
	localparam int CTRL_PLL_BIT     = 3;
	localparam int CTRL_MODE_LSB    = 4;
	localparam int CTRL_MODE_W      = 3;

	// status register field positions
	localparam int ST_OSC_GOOD_BIT  = 0;
	localparam int ST_CLK_ON_BIT    = 1;
	localparam int ST_WAKE_BIT      = 2;
	localparam int ST_BUTTON_BIT    = 3;
	localparam int ST_SUPPLY_BIT    = 4;
	localparam int ST_LOADCAP_BIT   = 5;
	localparam int ST_GATE_ARM_BIT  = 6;

	// synth word split: low part holds bits 0..7, high part bits 8..12
	localparam int WORD_W      = 13;
	localparam int LOW_W       = 8;
	localparam int HIGH_W      = 5;
	localparam int RATIO_W     = 22;

	// ratio is reported in units of 1/32768: base*32768 + 2*word + 49
	localparam logic [RATIO_W-1:0] BASE_315 = 22'h0C_4000;
	localparam logic [RATIO_W-1:0] BASE_433 = 22'h10_4000;
	localparam logic [RATIO_W-1:0] BASE_868 = 22'h20_4000;
	localparam logic [RATIO_W-1:0] FRAC_OFS = 22'h00_0031;

	// operating modes in the mode field
	localparam logic [2:0] MODE_IDLE      = 3'h0;
	localparam logic [2:0] MODE_TX        = 3'h1;
	localparam logic [2:0] MODE_RX_POLL   = 3'h2;
	localparam logic [2:0] MODE_RX        = 3'h3;
	localparam logic [2:0] MODE_FD_MASTER = 3'h4;
	localparam logic [2:0] MODE_FD_SLAVE  = 3'h5;
	localparam logic [2:0] MODE_SLEEP     = 3'h7;

	// reset values
	localparam logic [7:0] CTRL_RESET     = 8'h03;
	localparam logic [LOW_W-1:0]  LOW_RESET  = 8'h00;
	localparam logic [HIGH_W-1:0] HIGH_RESET = 5'h00;

	// clock-out divider, synchroniser depth and power-up capture wait
	localparam logic [1:0] DIV_LAST = 2'h2;
	localparam int SYNC_DEPTH = 2;
	localparam logic [1:0] CAPTURE_WAIT = 2'h3;

	typedef struct packed {
		logic [2:0] mode;
		logic       pll_mode;
		logic       band_bit;
		logic       request;
		logic       permit;
	} ctrl_t;

	typedef struct packed {
		logic gate_armed;
		logic load_cap_full;
		logic supply_ok;
		logic button_flag;
		logic wake_flag;
		logic clk_on;
		logic osc_good;
	} status_t;

endpackage

// ### src/pin_sync.sv
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds only sync_out
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### src/xto_clock_out_and_synth_word.sv
// clock output gating, wake flags and synthesizer word for the crystal oscillator section
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
//
// What this block does
// - the clock output pin runs at the crystal clock divided by three.
// - the output clock is high and low for equal times, a 50% duty cycle.
// - with the permit bit at zero the clock output stays off whatever else holds.
// - with permit set but the request bit at zero the clock output still stays off.
// - with request set the output turns on after a good bit-check in receive, polling or slave full-duplex mode, a button wake event, or the wake flag at one.
// - the oscillator-good signal rises once the amplitude detector reports enough swing.
// - the output is active only while oscillator-good, permit, request and the supply condition all hold.
// - the synth word is the sum of two partial values split over two registers, shaped by the pll mode bit.
// - the synth ratio is the band base plus (word + 24.5)/16384, base 24.5, 32.5 or 64.5 by band.
// - in idle and sleep modes part of the load capacitors is switched off, and on again otherwise.
// - a wake from off raises the interrupt line and sets the flag of the pin that caused it.
module xto_clock_out_and_synth_word (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        amplitude_detect,
	input  wire logic        supply_level_ok,
	input  wire logic        wake_input,
	input  wire logic        button_wake_input_n,
	input  wire logic        band_select_pin,
	input  wire logic        bitcheck_ok,
	output logic             clk_out,
	output logic             osc_amplitude_good,
	output logic             load_cap_full,
	output logic             irq_out,
	output logic [12:0]      synth_frequency_word,
	output logic [21:0]      synth_ratio
);
	typedef enum logic [1:0] {
		PWR_SETTLE,
		PWR_CAPTURE,
		PWR_RUN
	} power_state_t;

	xto_pkg::ctrl_t   ctrl_reg;
	xto_pkg::status_t status_now;
	logic [xto_pkg::LOW_W-1:0]  word_low_reg;
	logic [xto_pkg::HIGH_W-1:0] word_high_reg;
	logic [xto_pkg::WORD_W-1:0] word_next;
	logic [xto_pkg::RATIO_W-1:0] base_next;
	logic [xto_pkg::RATIO_W-1:0] ratio_next;

	logic [4:0] pins_sync;
	logic       amp_sync;
	logic       supply_sync;
	logic       wake_sync;
	logic       button_n_sync;
	logic       band_sync;
	logic       button_n_prev_reg;
	logic       button_event;

	power_state_t pwr_state_reg;
	logic [1:0]   settle_cnt_reg;
	logic         wake_flag_reg;
	logic         button_flag_reg;
	logic         osc_good_reg;
	logic         trigger_reg;
	logic         bitcheck_qualified;
	logic         enable_next;

	logic [1:0] div_cnt_reg;
	logic       gate_reg;
	logic       phase_pos_reg;
	logic       phase_neg_reg;

	logic       setup_phase;
	logic       access_phase;
	logic       addr_hit;
	logic       status_read;
	logic [31:0] read_next;

	// all asynchronous levels pass two flops before use; reset holds each pin's idle level
	pin_sync #(
		.WIDTH (5),
		.INIT  (5'h08)
	) u_pin_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({band_select_pin, button_wake_input_n, wake_input,
			supply_level_ok, amplitude_detect}),
		.sync_out (pins_sync)
	);

	assign amp_sync      = pins_sync[0];
	assign supply_sync   = pins_sync[1];
	assign wake_sync     = pins_sync[2];
	assign button_n_sync = pins_sync[3];
	assign band_sync     = pins_sync[4];

	// apb handshake: zero wait states
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign pready       = 1'b1;

	always_comb begin
		case (paddr)
			xto_pkg::ADDR_CTRL,
			xto_pkg::ADDR_WORD_LOW,
			xto_pkg::ADDR_WORD_HIGH,
			xto_pkg::ADDR_STATUS,
			xto_pkg::ADDR_RATIO: addr_hit = 1'b1;
			default:             addr_hit = 1'b0;
		endcase
	end

	assign pslverr     = access_phase && !addr_hit;
	assign status_read = access_phase && !pwrite && (paddr == xto_pkg::ADDR_STATUS);

	// control register writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= xto_pkg::ctrl_t'(xto_pkg::CTRL_RESET[6:0]);
		end else if (access_phase && pwrite && paddr == xto_pkg::ADDR_CTRL) begin
			ctrl_reg.permit   <= pwdata[xto_pkg::CTRL_PERMIT_BIT];
			ctrl_reg.request  <= pwdata[xto_pkg::CTRL_REQUEST_BIT];
			ctrl_reg.band_bit <= pwdata[xto_pkg::CTRL_BAND_BIT];
			ctrl_reg.pll_mode <= pwdata[xto_pkg::CTRL_PLL_BIT];
			ctrl_reg.mode     <= pwdata[xto_pkg::CTRL_MODE_LSB +: xto_pkg::CTRL_MODE_W];
		end
	end

	// the two partial word registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_low_reg  <= xto_pkg::LOW_RESET;
			word_high_reg <= xto_pkg::HIGH_RESET;
		end else if (access_phase && pwrite) begin
			if (paddr == xto_pkg::ADDR_WORD_LOW) begin
				word_low_reg <= pwdata[xto_pkg::LOW_W-1:0];
			end
			if (paddr == xto_pkg::ADDR_WORD_HIGH) begin
				word_high_reg <= pwdata[xto_pkg::HIGH_W-1:0];
			end
		end
	end

	// word is the sum of both parts; in integer pll mode the lowest bit is dropped
	always_comb begin
		word_next = 13'(word_low_reg) + 13'({word_high_reg, 8'h00});
		if (!ctrl_reg.pll_mode) begin
			word_next[0] = 1'b0;
		end
	end

	// band base: band bit wins, else the pin picks 433 or 868
	always_comb begin
		if (ctrl_reg.band_bit) begin
			base_next = xto_pkg::BASE_315;
		end else if (band_sync) begin
			base_next = xto_pkg::BASE_433;
		end else begin
			base_next = xto_pkg::BASE_868;
		end
		ratio_next = base_next + 22'({word_next, 1'b0}) + xto_pkg::FRAC_OFS;
	end

	// word and ratio are registered so the synthesizer sees stable values
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			synth_frequency_word <= '0;
			synth_ratio          <= '0;
		end else begin
			synth_frequency_word <= word_next;
			synth_ratio          <= ratio_next;
		end
	end

	// oscillator-good follows the synchronised amplitude detector
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_good_reg <= 1'b0;
		end else begin
			osc_good_reg <= amp_sync;
		end
	end

	assign osc_amplitude_good = osc_good_reg;

	// load capacitors are partly off in idle and sleep
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			load_cap_full <= 1'b0;
		end else begin
			load_cap_full <= (ctrl_reg.mode != xto_pkg::MODE_IDLE) &&
				(ctrl_reg.mode != xto_pkg::MODE_SLEEP);
		end
	end

	// power-up: wait for the synchronisers to fill, then record the wake cause once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwr_state_reg  <= PWR_SETTLE;
			settle_cnt_reg <= '0;
		end else begin
			case (pwr_state_reg)
				PWR_SETTLE: begin
					settle_cnt_reg <= settle_cnt_reg + 2'h1;
					if (settle_cnt_reg == xto_pkg::CAPTURE_WAIT) begin
						pwr_state_reg <= PWR_CAPTURE;
					end
				end
				PWR_CAPTURE: pwr_state_reg <= PWR_RUN;
				PWR_RUN:     pwr_state_reg <= PWR_RUN;
				default:     pwr_state_reg <= PWR_SETTLE;
			endcase
		end
	end

	// a falling button level counts as an event once running
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			button_n_prev_reg <= 1'b1;
		end else begin
			button_n_prev_reg <= button_n_sync;
		end
	end

	assign button_event = (pwr_state_reg == PWR_RUN) && button_n_prev_reg && !button_n_sync;

	// wake flags: a set in the same cycle as the clearing read wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_flag_reg   <= 1'b0;
			button_flag_reg <= 1'b0;
		end else begin
			if (pwr_state_reg == PWR_CAPTURE && wake_sync) begin
				wake_flag_reg <= 1'b1;
			end else if (status_read) begin
				wake_flag_reg <= 1'b0;
			end
			if ((pwr_state_reg == PWR_CAPTURE && !button_n_sync) || button_event) begin
				button_flag_reg <= 1'b1;
			end else if (status_read) begin
				button_flag_reg <= 1'b0;
			end
		end
	end

	// interrupt line stays high while any wake flag is pending
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= wake_flag_reg || button_flag_reg;
		end
	end

	// bit-check only counts in receive, polling and slave full-duplex modes
	assign bitcheck_qualified = bitcheck_ok && (ctrl_reg.mode == xto_pkg::MODE_RX ||
		ctrl_reg.mode == xto_pkg::MODE_RX_POLL || ctrl_reg.mode == xto_pkg::MODE_FD_SLAVE);

	// trigger is held until software drops the request; the pulse causes are short
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigger_reg <= 1'b0;
		end else if (!ctrl_reg.request) begin
			trigger_reg <= 1'b0;
		end else if (bitcheck_qualified || button_event || wake_flag_reg) begin
			trigger_reg <= 1'b1;
		end
	end

	always_comb begin
		enable_next = ctrl_reg.permit && ctrl_reg.request;
		enable_next = enable_next && osc_good_reg && supply_sync;
		enable_next = enable_next && (trigger_reg || bitcheck_qualified ||
			button_event || wake_flag_reg);
	end

	// divide by three counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
		end else if (div_cnt_reg == xto_pkg::DIV_LAST) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 2'h1;
		end
	end

	// gate changes only in the last count, when the output is already low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_reg <= 1'b0;
		end else if (div_cnt_reg == xto_pkg::DIV_LAST) begin
			gate_reg <= enable_next;
		end
	end

	// rising-edge phase is high for the first count of each period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_pos_reg <= 1'b0;
		end else begin
			phase_pos_reg <= enable_next && gate_or_arm(div_cnt_reg);
		end
	end

	// the falling-edge copy stretches high by half a cycle: 1.5 of 3 cycles.
	// this needs the falling edge of clk; an odd ratio cannot be 50% otherwise
	always_ff @(negedge clk) begin
		if (!rst_n) begin
			phase_neg_reg <= 1'b0;
		end else begin
			phase_neg_reg <= phase_pos_reg;
		end
	end

	assign clk_out = phase_pos_reg || phase_neg_reg;

	// a new high phase may only start at the period boundary
	function automatic logic gate_or_arm(input logic [1:0] cnt);
		gate_or_arm = (cnt == xto_pkg::DIV_LAST);
	endfunction

	// status snapshot
	always_comb begin
		status_now.osc_good      = osc_good_reg;
		status_now.clk_on        = gate_reg;
		status_now.wake_flag     = wake_flag_reg;
		status_now.button_flag   = button_flag_reg;
		status_now.supply_ok     = supply_sync;
		status_now.load_cap_full = load_cap_full;
		status_now.gate_armed    = trigger_reg;
	end

	always_comb begin
		case (paddr)
			xto_pkg::ADDR_CTRL:      read_next = 32'({ctrl_reg});
			xto_pkg::ADDR_WORD_LOW:  read_next = 32'(word_low_reg);
			xto_pkg::ADDR_WORD_HIGH: read_next = 32'(word_high_reg);
			xto_pkg::ADDR_STATUS:    read_next = 32'({status_now});
			xto_pkg::ADDR_RATIO:     read_next = 32'(synth_ratio);
			default:                 read_next = 32'h0000_0000;
		endcase
	end

	// read data is loaded in the setup cycle and held through the access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= read_next;
		end
	end
endmodule

// ### test/xto_clock_out_and_synth_word_properties.sv
// assertion checker for the clock-out gating and synth word block
`timescale 1ns/1ps
module xto_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        supply_level_ok,
	input wire logic        amplitude_detect,
	input wire logic        band_select_pin,
	input wire logic        clk_out,
	input wire logic        osc_amplitude_good,
	input wire logic        load_cap_full,
	input wire logic [12:0] synth_frequency_word,
	input wire logic [21:0] synth_ratio
);
	// shadow copies of the writable registers, rebuilt from bus writes
	logic [7:0]  ctrl_reg;
	logic [7:0]  low_reg;
	logic [4:0]  high_reg;
	logic [12:0] word_exp;
	logic [21:0] base_exp;
	logic [2:0]  mode;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= xto_pkg::CTRL_RESET;
			low_reg <= xto_pkg::LOW_RESET;
			high_reg <= xto_pkg::HIGH_RESET;
		end else if (psel && penable && pwrite) begin
			if (paddr == xto_pkg::ADDR_CTRL) ctrl_reg <= pwdata[7:0];
			if (paddr == xto_pkg::ADDR_WORD_LOW) low_reg <= pwdata[7:0];
			if (paddr == xto_pkg::ADDR_WORD_HIGH) high_reg <= pwdata[4:0];
		end
	end

	assign mode = ctrl_reg[6:4];
	assign word_exp = {high_reg, low_reg[7:1], low_reg[0] & ctrl_reg[3]};
	// the band bit wins over the pin
	assign base_exp = ctrl_reg[2] ? xto_pkg::BASE_315 :
		(band_select_pin ? xto_pkg::BASE_433 : xto_pkg::BASE_868);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_one_high;
		clk_out ##1 !clk_out;
	endsequence
	sequence s_regs_still;
		$stable({ctrl_reg, low_reg, high_reg, band_select_pin});
	endsequence

	property p_period;
		$rose(clk_out) |-> s_one_high ##1 !clk_out;
	endproperty
	a_period: assert property (p_period) else $error("divided clock period wrong");
	property p_permit_off;
		!ctrl_reg[0] [*6] |-> !clk_out;
	endproperty
	a_permit_off: assert property (p_permit_off) else $error("clock out with permit low");
	property p_request_off;
		!ctrl_reg[1] [*6] |-> !clk_out;
	endproperty
	a_request_off: assert property (p_request_off) else $error("clock out without request");
	property p_osc_off;
		!osc_amplitude_good [*6] |-> !clk_out;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("clock out with oscillator not good");
	property p_supply_off;
		!supply_level_ok [*8] |-> !clk_out;
	endproperty
	a_supply_off: assert property (p_supply_off) else $error("clock out without supply");
	property p_word;
		s_regs_still [*2] |-> synth_frequency_word == word_exp;
	endproperty
	a_word: assert property (p_word) else $error("synth word wrong");
	property p_ratio;
		s_regs_still [*5] |-> synth_ratio == base_exp + {8'h00, word_exp, 1'b0} + xto_pkg::FRAC_OFS;
	endproperty
	a_ratio: assert property (p_ratio) else $error("synth ratio wrong");
	property p_loadcap;
		$stable(mode) [*3] |->
			load_cap_full == !(mode == xto_pkg::MODE_IDLE || mode == xto_pkg::MODE_SLEEP);
	endproperty
	a_loadcap: assert property (p_loadcap) else $error("load capacitor state wrong");
	// two synchroniser flops and the output flop: five samples cover the lag
	property p_osc_good;
		amplitude_detect [*5] |-> osc_amplitude_good;
	endproperty
	a_osc_good: assert property (p_osc_good) else $error("oscillator good not raised");
	property p_osc_lost;
		!amplitude_detect [*5] |-> !osc_amplitude_good;
	endproperty
	a_osc_lost: assert property (p_osc_lost) else $error("oscillator good not dropped");
endmodule

bind xto_clock_out_and_synth_word xto_checker u_checker (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .supply_level_ok(supply_level_ok),
	.amplitude_detect(amplitude_detect),
	.band_select_pin(band_select_pin), .clk_out(clk_out),
	.osc_amplitude_good(osc_amplitude_good), .load_cap_full(load_cap_full),
	.synth_frequency_word(synth_frequency_word), .synth_ratio(synth_ratio)
);

// ### test/mcu_clock_model.sv
// microcontroller clocked from the divided output: counts and times its clock
`timescale 1ns/1ps
module mcu_clock_model (
	input wire logic clk_out,
	output int       rise_count,
	output real      high_ns,
	output real      period_ns
);
	real last_rise;

	initial begin
		rise_count = 0;
		high_ns = 0.0;
		period_ns = 0.0;
		last_rise = 0.0;
	end
	always @(posedge clk_out) begin
		period_ns = $realtime - last_rise;
		last_rise = $realtime;
		rise_count++;
	end
	always @(negedge clk_out) begin
		high_ns = $realtime - last_rise;
	end
endmodule

// ### test/xto_clock_out_and_synth_word_test.sv
// self-checking bench for the clock-out gating and synth word block
`timescale 1ns/1ps
module xto_clock_out_and_synth_word_test;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic        amplitude_detect, supply_level_ok, wake_input, button_wake_input_n;
	logic        band_select_pin, bitcheck_ok, clk_out, osc_amplitude_good;
	logic        load_cap_full, irq_out;
	logic [12:0] synth_frequency_word, wv, ew;
	logic [21:0] synth_ratio;
	logic [2:0]  modes [7];
	int          rise_count, err_total, tests_run, cycles, n0;
	real         high_ns, period_ns;
	integer      seed;

	xto_clock_out_and_synth_word u_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .amplitude_detect(amplitude_detect),
		.supply_level_ok(supply_level_ok), .wake_input(wake_input),
		.button_wake_input_n(button_wake_input_n), .band_select_pin(band_select_pin),
		.bitcheck_ok(bitcheck_ok), .clk_out(clk_out), .osc_amplitude_good(osc_amplitude_good),
		.load_cap_full(load_cap_full), .irq_out(irq_out),
		.synth_frequency_word(synth_frequency_word), .synth_ratio(synth_ratio));
	mcu_clock_model u_mcu (.clk_out(clk_out), .rise_count(rise_count),
		.high_ns(high_ns), .period_ns(period_ns));

	task automatic complete_run();
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_ns(input string name, input real exp, input real got);
		tests_run++;
		if (got < exp - 0.01 || got > exp + 0.01) begin
			err_total++;
			$display("CHECK FAILED %s expected %f seen %f", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// entered just after a rising edge; leaves one idle edge so psel is never driven twice
	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [12:0] word_of(input logic [12:0] w, input logic pll);
		word_of = {w[12:1], w[0] & pll};
	endfunction
	function automatic logic [21:0] ratio_of(input logic [12:0] w, input logic fs, input logic pin);
		logic [21:0] b;
		b = fs ? xto_pkg::BASE_315 : (pin ? xto_pkg::BASE_433 : xto_pkg::BASE_868);
		ratio_of = b + {8'h00, w, 1'b0} + xto_pkg::FRAC_OFS;
	endfunction
	// clock-out count over a quiet window; expects no new rising edge
	task automatic expect_quiet(input string name);
		tick(8);
		n0 = rise_count;
		tick(12);
		check(name, n0, rise_count);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			complete_run();
		end
	end

	initial begin
		seed = 32'h0fb9_2b7c;
		{err_total, tests_run, cycles} = '0;
		modes = '{xto_pkg::MODE_IDLE, xto_pkg::MODE_TX, xto_pkg::MODE_RX_POLL, xto_pkg::MODE_RX,
			xto_pkg::MODE_FD_MASTER, xto_pkg::MODE_FD_SLAVE, xto_pkg::MODE_SLEEP};
		{rst_n, psel, penable, pwrite, paddr, pwdata, bitcheck_ok, band_select_pin} = '0;
		{amplitude_detect, supply_level_ok, wake_input, button_wake_input_n} = 4'hf;
		tick(6);
		rst_n <= 1'b1;
		tick(30);
		wake_input <= 1'b0;
		check("irq", 1, irq_out);
		check("osc good", 1, osc_amplitude_good);
		check("clock started", 1, rise_count > 3);
		check_ns("period", 75.0, period_ns);
		check_ns("high time", 37.5, high_ns);
		apb(1'b0, xto_pkg::ADDR_CTRL, 32'h0);
		check("ctrl reset", 32'h0000_0003, rd);
		check("mapped err", 0, err);
		apb(1'b0, xto_pkg::ADDR_STATUS, 32'h0);
		check("wake flag", 1, rd[2]);
		// irq follows the cleared flags one edge after the access
		tick(1);
		check("irq cleared", 0, irq_out);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped err", 1, err);
		check("unmapped data", 32'h0, rd);
		// t 0 wakes by button in rx, t 1..3 by bit-check in rx, polling and slave full-duplex
		for (int t = 0; t < 4; t++) begin
			apb(1'b1, xto_pkg::ADDR_CTRL, 32'h0000_0001);
			apb(1'b0, xto_pkg::ADDR_STATUS, 32'h0);
			check("button flag", (t == 1), rd[3]);
			expect_quiet("request off");
			apb(1'b1, xto_pkg::ADDR_CTRL, {25'h0, xto_pkg::MODE_FD_MASTER, 4'h3});
			bitcheck_ok <= 1'b1;
			expect_quiet("no trigger");
			bitcheck_ok <= 1'b0;
			apb(1'b1, xto_pkg::ADDR_CTRL,
				{25'h0, modes[(t == 3) ? 5 : ((t == 2) ? 2 : 3)], 4'h3});
			button_wake_input_n <= (t != 0);
			bitcheck_ok <= (t != 0);
			tick(4);
			button_wake_input_n <= 1'b1;
			bitcheck_ok <= 1'b0;
			tick(12);
			check("triggered", 1, rise_count > n0 + 2);
		end
		apb(1'b1, xto_pkg::ADDR_CTRL, {25'h0, xto_pkg::MODE_RX, 4'h2});
		expect_quiet("permit off");
		apb(1'b1, xto_pkg::ADDR_CTRL, {25'h0, xto_pkg::MODE_RX, 4'h3});
		supply_level_ok <= 1'b0;
		expect_quiet("supply off");
		supply_level_ok <= 1'b1;
		amplitude_detect <= 1'b0;
		expect_quiet("osc off");
		check("osc low", 0, osc_amplitude_good);
		amplitude_detect <= 1'b1;
		for (int m = 0; m < 7; m++) begin
			apb(1'b1, xto_pkg::ADDR_CTRL, {25'h0, modes[m], 4'h3});
			tick(3);
			check("load caps", (m != 0 && m != 6), load_cap_full);
		end
		for (int i = 0; i < 10; i++) begin
			r = $random(seed);
			wv = (i == 0) ? 13'h0edb : ((i == 1) ? 13'h0fd5 : r[12:0]);
			band_select_pin <= r[13];
			apb(1'b1, xto_pkg::ADDR_CTRL, {25'h0, xto_pkg::MODE_RX, r[15:14], 2'b11});
			apb(1'b1, xto_pkg::ADDR_WORD_LOW, {24'h0, wv[7:0]});
			apb(1'b1, xto_pkg::ADDR_WORD_HIGH, {27'h0, wv[12:8]});
			tick(5);
			ew = word_of(wv, r[15]);
			check("synth word", ew, synth_frequency_word);
			check("synth ratio", ratio_of(ew, r[14], r[13]), synth_ratio);
			apb(1'b0, xto_pkg::ADDR_RATIO, 32'h0);
			check("ratio reg", ratio_of(ew, r[14], r[13]), rd);
		end
		// second power-up, this time woken by the button pin
		rst_n <= 1'b0;
		button_wake_input_n <= 1'b0;
		tick(6);
		rst_n <= 1'b1;
		tick(12);
		check("irq button wake", 1, irq_out);
		apb(1'b0, xto_pkg::ADDR_STATUS, 32'h0);
		check("button wake flags", 2'b10, rd[3:2]);
		button_wake_input_n <= 1'b1;
		complete_run();
	end
endmodule
